// >>> rtl/api_pkg.sv
package api_pkg;
  localparam int NUM_AXES = 8;
  localparam int NUM_GEN_IN = 16;
  localparam int POS_W = 32;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int SYNC_W = 1 + NUM_GEN_IN + 3 * NUM_AXES;
  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] SHUTDOWN_CFG_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] CMD_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h0C;
  localparam logic [ADDR_W-1:0] THRESH_BASE_OFF = 8'h20;
  // control fields
  localparam int CTRL_W = 4;
  localparam int CTRL_HALT_DIS = 0;
  localparam int CTRL_AXIS_ABORT = 1;
  localparam int CTRL_LIMIT_HIGH = 2;
  localparam int CTRL_DRIVE_INV = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
  // command fields
  localparam int CMD_MOTOR_OFF = 0;
  localparam int CMD_SERVO_HERE = 8;
  localparam int CMD_RESET = 16;
  localparam int CMD_ABORT = 17;
  // status fields
  localparam int STAT_ENABLED = 0;
  localparam int STAT_POS_FAULT = 8;
  localparam int STAT_WATCHDOG = 16;
  localparam int STAT_HALTED = 17;
  // shutdown-on-fault codes, two bits per axis
  localparam int OE_W = 2;
  localparam logic [OE_W-1:0] OE_OFF = 2'h0;
  localparam logic [OE_W-1:0] OE_ERR_ABORT = 2'h1;
  localparam logic [OE_W-1:0] OE_LIMIT = 2'h2;
  localparam logic [OE_W-1:0] OE_ALL = 2'h3;
  localparam logic [NUM_AXES*OE_W-1:0] OE_RST = 16'h0000;
  localparam logic [POS_W-1:0] THRESH_RST = 32'h0000_4000;
  // general inputs 5..8,13..16 (one based) abort axes A..H
  localparam int ABORT_IN_IDX [NUM_AXES] = '{4, 5, 6, 7, 12, 13, 14, 15};
endpackage

// >>> rtl/api_interlock.sv
`timescale 1ns/1ps
// What this block does
// - motor off, position fault or abort with shutdown enabled kill drive
// - each axis has its own drive enable
// - watchdog or reset disables every drive
// - drive enable active high, polarity selectable
// - fault output low and lamp lit on error
// - general abort stops motion instantly, no ramp
// - general abort disables axes with shutdown enabled
// - other axes stop and hold, drive enabled
// - abort halts program unless config disables halt
// - inputs 5-8,13-16 abort axes A-H when enabled
// - per-axis abort acts like general on one axis, but does not halt program
// - forward limit blocks forward motion, decelerates
// - reverse limit blocks reverse motion, decelerates
// - limit while moving toward it signals handler
// - limit input polarity is configurable
// - shutdown setting may let limits disable drive
// - lockout input shuts amplifier down directly
// - shutdown codes: 0 off, 2 limits, 3 all
// - fault when position difference exceeds threshold 16384
// - motor off, position fault or shutdown keeps axis off until reset or servo-here
module api_interlock
  import api_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic abort_n,
  input wire logic [NUM_GEN_IN-1:0] gen_in_n,
  input wire logic [NUM_AXES-1:0] hardware_lockout_in_n,
  input wire logic [NUM_AXES-1:0] fwd_limit_in,
  input wire logic [NUM_AXES-1:0] rev_limit_in,
  input wire logic [NUM_AXES-1:0] moving_fwd,
  input wire logic [NUM_AXES-1:0] moving_rev,
  input wire logic [NUM_AXES*POS_W-1:0] pos_cmd,
  input wire logic [NUM_AXES*POS_W-1:0] pos_act,
  input wire logic watchdog_fire,
  input wire logic handler_present,
  output logic [NUM_AXES-1:0] amp_drive_enable,
  output logic [NUM_AXES-1:0] stop_hold,
  output logic [NUM_AXES-1:0] decel_stop,
  output logic [NUM_AXES-1:0] inhibit_fwd,
  output logic [NUM_AXES-1:0] inhibit_rev,
  output logic halt_program,
  output logic travel_stop_handler,
  output logic fault_n,
  output logic error_lamp
);

  // byte-lane merge for wishbone writes
  function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_v,
                                                   input logic [DATA_W-1:0] new_v,
                                                   input logic [3:0] sel);
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = new_v[8*b +: 8];
    end
    return r;
  endfunction

  // magnitude of commanded minus actual position
  function automatic logic [POS_W:0] abs_diff(input logic [POS_W-1:0] a,
                                              input logic [POS_W-1:0] b);
    logic signed [POS_W:0] d;
    d = $signed({a[POS_W-1], a}) - $signed({b[POS_W-1], b});
    return d[POS_W] ? -d : d;
  endfunction

  logic [SYNC_W-1:0] s1_q, s1_d, s2_q, s2_d;
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [NUM_AXES*OE_W-1:0] oe_q, oe_d;
  logic [POS_W-1:0] thr_q [NUM_AXES];
  logic [POS_W-1:0] thr_d [NUM_AXES];
  logic ack_q, ack_d;
  logic [DATA_W-1:0] dat_q, dat_d;
  logic wr;
  logic [NUM_AXES-1:0] mo_cmd, sh_cmd;
  logic rst_cmd, abort_cmd;
  logic [DATA_W-1:0] ctrl_m, oe_m, cmd_m;

  logic [NUM_AXES-1:0] off_q, off_d, amp_q, amp_d, stop_q, stop_d, decel_q, decel_d;
  logic [NUM_AXES-1:0] inf_q, inf_d, inr_q, inr_d, lf_prev_q, lr_prev_q;
  logic [NUM_AXES-1:0] lf_vec, lr_vec, pf_vec, lock_vec, pf_q;
  logic wd_q, wd_d, halt_q, halt_d, hnd_q, hnd_d, err_q, err_d;
  logic s_abort;
  logic [NUM_GEN_IN-1:0] s_gen;
  logic [NUM_AXES-1:0] s_lock, s_fwd, s_rev;

  // two-stage synchronisers; only stage two is looked at
  always_comb begin
    s1_d = {abort_n, gen_in_n, hardware_lockout_in_n, fwd_limit_in, rev_limit_in};
    s2_d = s1_q;
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s1_q <= '1;
      s2_q <= '1;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  assign {s_abort, s_gen, s_lock, s_fwd, s_rev} = s2_q;

  // wishbone slave: ack one cycle after the strobe, writes land on the ack edge
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;

  always_comb begin
    ctrl_d = ctrl_q;
    oe_d = oe_q;
    thr_d = thr_q;
    dat_d = dat_q;
    mo_cmd = '0;
    sh_cmd = '0;
    rst_cmd = 1'b0;
    abort_cmd = 1'b0;
    ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
    // merged write words; a function result cannot be sliced in place
    ctrl_m = lane_merge(DATA_W'(ctrl_q), wb_dat_i, wb_sel_i);
    oe_m = lane_merge(DATA_W'(oe_q), wb_dat_i, wb_sel_i);
    cmd_m = lane_merge('0, wb_dat_i, wb_sel_i);
    if (ack_d) begin
      dat_d = '0;  // unmapped reads answer zero
      unique case (wb_adr_i)
        CTRL_OFF: dat_d[CTRL_W-1:0] = ctrl_q;
        SHUTDOWN_CFG_OFF: dat_d[NUM_AXES*OE_W-1:0] = oe_q;
        STATUS_OFF: begin
          dat_d[STAT_ENABLED +: NUM_AXES] = ~off_q & lock_vec & {NUM_AXES{~wd_q}};
          dat_d[STAT_POS_FAULT +: NUM_AXES] = pf_q;
          dat_d[STAT_WATCHDOG] = wd_q;
          dat_d[STAT_HALTED] = halt_q;
        end
        default: begin
          for (int i = 0; i < NUM_AXES; i++) begin
            if (wb_adr_i == THRESH_BASE_OFF + ADDR_W'(4 * i)) dat_d = thr_q[i];
          end
        end
      endcase
    end
    if (wr) begin
      unique case (wb_adr_i)
        CTRL_OFF: ctrl_d = ctrl_m[CTRL_W-1:0];
        SHUTDOWN_CFG_OFF: begin
          oe_d = oe_m[NUM_AXES*OE_W-1:0];
        end
        CMD_OFF: begin
          // commands are pulses; nothing is stored
          mo_cmd = cmd_m[CMD_MOTOR_OFF +: NUM_AXES];
          sh_cmd = cmd_m[CMD_SERVO_HERE +: NUM_AXES];
          rst_cmd = cmd_m[CMD_RESET];
          abort_cmd = cmd_m[CMD_ABORT];
        end
        default: begin
          for (int i = 0; i < NUM_AXES; i++) begin
            if (wb_adr_i == THRESH_BASE_OFF + ADDR_W'(4 * i)) begin
              thr_d[i] = lane_merge(thr_q[i], wb_dat_i, wb_sel_i);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RST;
      oe_q <= OE_RST;
      for (int i = 0; i < NUM_AXES; i++) thr_q[i] <= THRESH_RST;
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      oe_q <= oe_d;
      thr_q <= thr_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // per-axis interlock; every axis has its own chain, no cross coupling
  always_comb begin
    logic ab_gen, ab, shut_ab, shut_lim;
    logic [OE_W-1:0] oe;
    logic [NUM_AXES-1:0] ev;
    ab_gen = ~s_abort | abort_cmd;
    ab = 1'b0;
    shut_ab = 1'b0;
    shut_lim = 1'b0;
    oe = OE_OFF;
    ev = '0;
    wd_d = watchdog_fire | (wd_q & ~rst_cmd);
    for (int i = 0; i < NUM_AXES; i++) begin
      ab = ab_gen | (ctrl_q[CTRL_AXIS_ABORT] & ~s_gen[ABORT_IN_IDX[i]]);
      lf_vec[i] = ctrl_q[CTRL_LIMIT_HIGH] ? s_fwd[i] : ~s_fwd[i];
      lr_vec[i] = ctrl_q[CTRL_LIMIT_HIGH] ? s_rev[i] : ~s_rev[i];
      lock_vec[i] = s_lock[i];
      pf_vec[i] = abs_diff(pos_cmd[i*POS_W +: POS_W], pos_act[i*POS_W +: POS_W])
                  > {1'b0, thr_q[i]};
      oe = oe_q[i*OE_W +: OE_W];
      shut_ab = ab & (oe == OE_ERR_ABORT || oe == OE_ALL);
      shut_lim = (lf_vec[i] | lr_vec[i]) & (oe == OE_LIMIT || oe == OE_ALL);
      // set wins over a same-cycle servo-here or reset
      off_d[i] = mo_cmd[i] | pf_vec[i] | shut_ab | shut_lim
                 | (off_q[i] & ~(sh_cmd[i] | rst_cmd));
      amp_d[i] = (~off_d[i] & ~wd_d & lock_vec[i]) ^ ctrl_q[CTRL_DRIVE_INV];
      // any disable cause, lockout and watchdog too, beats stop and hold
      stop_d[i] = ab & ~off_d[i] & ~wd_d & lock_vec[i];
      decel_d[i] = (lf_vec[i] & moving_fwd[i]) | (lr_vec[i] & moving_rev[i]);
      inf_d[i] = lf_vec[i];
      inr_d[i] = lr_vec[i];
      ev[i] = (lf_vec[i] & moving_fwd[i] & ~lf_prev_q[i])
              | (lr_vec[i] & moving_rev[i] & ~lr_prev_q[i]);
    end
    hnd_d = handler_present & (|ev);
    halt_d = (ab_gen & ~ctrl_q[CTRL_HALT_DIS]) | (halt_q & ~rst_cmd);
    err_d = (|pf_vec) | wd_d;
  end

  // reset leaves every drive at its disabled level
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      off_q <= '0;
      amp_q <= '0;
      stop_q <= '0;
      decel_q <= '0;
      inf_q <= '0;
      inr_q <= '0;
      lf_prev_q <= '0;
      lr_prev_q <= '0;
      pf_q <= '0;
      wd_q <= 1'b0;
      halt_q <= 1'b0;
      hnd_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      off_q <= off_d;
      amp_q <= amp_d;
      stop_q <= stop_d;
      decel_q <= decel_d;
      inf_q <= inf_d;
      inr_q <= inr_d;
      lf_prev_q <= lf_vec;
      lr_prev_q <= lr_vec;
      pf_q <= pf_vec;
      wd_q <= wd_d;
      halt_q <= halt_d;
      hnd_q <= hnd_d;
      err_q <= err_d;
    end
  end

  assign amp_drive_enable = amp_q;
  assign stop_hold = stop_q;
  assign decel_stop = decel_q;
  assign inhibit_fwd = inf_q;
  assign inhibit_rev = inr_q;
  assign halt_program = halt_q;
  assign travel_stop_handler = hnd_q;
  assign fault_n = ~err_q;
  assign error_lamp = err_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_watchdog_drive_off: assert property (watchdog_fire && !ctrl_q[CTRL_DRIVE_INV]
    |=> amp_drive_enable == '0) else $error("watchdog left a drive on");
  a_motor_off_drive: assert property ((|mo_cmd) && !ctrl_q[CTRL_DRIVE_INV]
    |=> (amp_drive_enable & $past(mo_cmd)) == '0) else $error("motor off ignored");
  a_off_latch_holds: assert property ((|(off_q & ~sh_cmd)) && !rst_cmd
    |=> (off_q & $past(off_q & ~sh_cmd)) == $past(off_q & ~sh_cmd))
    else $error("disable released early");
  a_fault_lamp_on: assert property ((|pf_vec) |=> !fault_n && error_lamp)
    else $error("fault output not asserted");
  // outputs were registered with last cycle's polarity bit
  a_hold_not_off: assert property (!$past(ctrl_q[CTRL_DRIVE_INV])
    |-> (stop_hold & ~amp_drive_enable) == '0) else $error("hold on a disabled axis");
  a_abort_halt: assert property ((!abort_n && !ctrl_q[CTRL_HALT_DIS])[*3]
    |=> halt_program) else $error("abort did not halt program");
  a_fwd_limit_decel: assert property ((|(lf_vec & moving_fwd))
    |=> (decel_stop & inhibit_fwd & $past(lf_vec & moving_fwd)) == $past(lf_vec & moving_fwd))
    else $error("forward limit ignored");
  a_rev_limit_decel: assert property ((|(lr_vec & moving_rev))
    |=> (decel_stop & inhibit_rev & $past(lr_vec & moving_rev)) == $past(lr_vec & moving_rev))
    else $error("reverse limit ignored");
  a_lockout_drive_off: assert property ((|(~lock_vec)) && !ctrl_q[CTRL_DRIVE_INV]
    |=> (amp_drive_enable & ~$past(lock_vec)) == '0) else $error("lockout left drive on");

  c_abort_hold: cover property (|stop_hold);
  c_limit_handler: cover property (travel_stop_handler);
  c_servo_here_reenable: cover property ((|off_q) ##1 (off_q == '0));
  c_lockout_trip: cover property (|(~lock_vec));
  c_position_fault: cover property (|pf_q);
endmodule

// >>> verification/api_field.sv
`timescale 1ns/1ps
// switch bank and motion sense facing the interlock
module api_field (
  input wire logic sys_clk,
  output logic abort_n,
  output logic [15:0] gen_in_n,
  output logic [7:0] lock_n,
  output logic [7:0] fwd_n,
  output logic [7:0] mov_f,
  output logic [7:0] rev_n,
  output logic [7:0] mov_r
);
  // contacts open and pulled high, axes at rest
  initial begin
    abort_n = 1'b1;
    gen_in_n = 16'hFFFF;
    lock_n = 8'hFF;
    fwd_n = 8'hFF;
    mov_f = 8'h00;
    rev_n = 8'hFF;
    mov_r = 8'h00;
  end
  // a contact only moves just after an edge, so the syncs see a clean step
  task automatic put(input int k, input logic [15:0] v);
    @(posedge sys_clk);
    case (k)
      0: abort_n <= v[0];
      1: gen_in_n <= v;
      2: lock_n <= v[7:0];
      3: fwd_n <= v[7:0];
      4: mov_f <= v[7:0];
      5: rev_n <= v[7:0];
      default: mov_r <= v[7:0];
    endcase
  endtask
endmodule

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import api_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic wdog = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic [3:0] sel = '0;
  logic [DATA_W-1:0] wdat = '0;
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] dat_o;
  logic [NUM_AXES*POS_W-1:0] pcmd = '0;
  logic [NUM_AXES*POS_W-1:0] pact = '0;
  logic abort_n, ack, halt, tsh, fault_n, lamp;
  logic [15:0] gen_n;
  logic [7:0] lock_n, fwd_n, mov_f, amp, sh, dst, inf, inr, rev_n, mov_r;
  int err_total = 0;
  int cmp_count = 0;
  int tmo = 0;
  int hnd = 0;
  // switch bank drives both travel directions
  api_field i_api_field (.sys_clk(sys_clk), .abort_n(abort_n), .gen_in_n(gen_n),
    .lock_n(lock_n), .fwd_n(fwd_n), .mov_f(mov_f), .rev_n(rev_n), .mov_r(mov_r));
  api_interlock i_api_interlock (.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .abort_n(abort_n), .gen_in_n(gen_n),
    .hardware_lockout_in_n(lock_n), .fwd_limit_in(fwd_n), .rev_limit_in(rev_n),
    .moving_fwd(mov_f), .moving_rev(mov_r), .pos_cmd(pcmd), .pos_act(pact),
    .watchdog_fire(wdog), .handler_present(1'b1), .amp_drive_enable(amp),
    .stop_hold(sh), .decel_stop(dst), .inhibit_fwd(inf), .inhibit_rev(inr),
    .halt_program(halt), .travel_stop_handler(tsh), .fault_n(fault_n),
    .error_lamp(lamp));
  // clock and hang guard
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    tmo++;
    if (tsh === 1'b1) hnd++;
    if (tmo == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one classic cycle; waits on ack, no latency assumed
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do @(posedge sys_clk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence
  initial begin
    w(8);
    chk(amp, 8'h00);
    chk(fault_n, 1'b1);
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    w(6);
    chk(amp, 8'hFF);
    wb(0, THRESH_BASE_OFF + 8'h1C, 0);
    chk(rd, THRESH_RST);
    wb(0, 8'h80, 0);
    chk(rd, 0);
    wb(1, CMD_OFF, 32'h1 << (CMD_MOTOR_OFF + 5));
    w(2);
    chk(amp, 8'hDF);
    wb(1, CMD_OFF, 32'h1 << (CMD_SERVO_HERE + 5));
    w(2);
    chk(amp, 8'hFF);
    // general abort on all axes, B set to coast
    wb(1, SHUTDOWN_CFG_OFF, 32'(OE_ALL) << 2);
    i_api_field.put(0, 0);
    w(4);
    chk(amp, 8'hFD);
    chk(sh, 8'hFD);
    chk(halt, 1'b1);
    i_api_field.put(0, 1);
    w(4);
    chk(amp, 8'hFD);
    wb(1, CMD_OFF, 32'h1 << CMD_RESET);
    w(2);
    chk(amp, 8'hFF);
    wb(1, CMD_OFF, 32'h1 << CMD_ABORT);
    w(2);
    chk(amp, 8'hFD);
    wb(1, CMD_OFF, 32'h1 << CMD_RESET);
    wb(1, CTRL_OFF, 32'h1 << CTRL_HALT_DIS);
    i_api_field.put(0, 0);
    w(4);
    chk(halt, 1'b0);
    i_api_field.put(0, 1);
    // per-axis abort on G and H, H set to coast
    wb(1, SHUTDOWN_CFG_OFF, 32'(OE_ERR_ABORT) << 14);
    wb(1, CTRL_OFF, 32'h1 << CTRL_AXIS_ABORT);
    wb(1, CMD_OFF, 32'h1 << CMD_RESET);
    i_api_field.put(1, ~((16'h1 << ABORT_IN_IDX[7]) | (16'h1 << ABORT_IN_IDX[6])));
    w(4);
    chk(amp, 8'h7F);
    chk(sh, 8'h40);
    i_api_field.put(1, 16'hFFFF);
    wb(1, CMD_OFF, 32'h1 << CMD_RESET);
    // limit hit while moving toward it
    wb(1, SHUTDOWN_CFG_OFF, 32'(OE_LIMIT) << 4);
    wb(1, CTRL_OFF, 0);
    i_api_field.put(4, 8'h04);
    i_api_field.put(3, 8'hFB);
    w(4);
    chk(dst, 8'h04);
    chk(inf, 8'h04);
    chk(amp, 8'hFB);
    chk(hnd, 1);
    wb(1, SHUTDOWN_CFG_OFF, 0);
    i_api_field.put(3, 8'hFF);
    i_api_field.put(4, 0);
    // reverse limit hit while moving in reverse, no shutdown code
    i_api_field.put(6, 8'h40);
    i_api_field.put(5, 8'hBF);
    w(4);
    chk(dst, 8'h40);
    chk(inr, 8'h40);
    chk(hnd, 2);
    i_api_field.put(5, 8'hFF);
    i_api_field.put(6, 0);
    wb(1, CTRL_OFF, 32'h1 << CTRL_LIMIT_HIGH);
    w(4);
    chk(inf, 8'hFF);
    chk(inr, 8'hFF);
    wb(1, CTRL_OFF, 32'h1 << CTRL_DRIVE_INV);
    wb(1, CMD_OFF, 32'hFF << CMD_SERVO_HERE);
    w(2);
    chk(amp, 8'h00);
    wb(1, CTRL_OFF, 0);
    i_api_field.put(2, 8'hEF);
    w(4);
    chk(amp, 8'hEF);
    i_api_field.put(2, 8'hFF);
    w(4);
    chk(amp, 8'hFF);
    // error exactly at threshold, then one count past it
    @(posedge sys_clk) pcmd[127:96] <= 32'h0000_4000;
    w(2);
    chk(amp, 8'hFF);
    @(posedge sys_clk) pcmd[127:96] <= 32'h0000_4001;
    w(2);
    chk(amp, 8'hF7);
    chk(fault_n, 1'b0);
    chk(lamp, 1'b1);
    @(posedge sys_clk) pcmd[127:96] <= '0;
    wb(1, CMD_OFF, 32'h1 << (CMD_SERVO_HERE + 3));
    w(2);
    chk(amp, 8'hFF);
    @(posedge sys_clk) wdog <= 1'b1;
    w(3);
    chk(amp, 8'h00);
    chk(fault_n, 1'b0);
    @(posedge sys_clk) wdog <= 1'b0;
    wb(1, CMD_OFF, 32'h1 << CMD_RESET);
    w(2);
    chk(amp, 8'hFF);
    chk(lamp, 1'b0);
    report_and_stop();
  end
endmodule
